/* File: include/wdcs_pkg.sv */
package wdcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_WAKE_CSL   = 8'h00;
  localparam logic [7:0] OFF_RESUME_CFG = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h0C;

  // Field layout of wake_control_status_low
  localparam int CSL_W          = 9;
  localparam int FIELD_W        = 4;
  localparam int EN_LSB         = 0;
  localparam int SEEN_LSB       = 4;
  localparam int BIT_BC_EN      = 0;
  localparam int BIT_PAT_EN     = 1;
  localparam int BIT_FILT_EN    = 2;
  localparam int BIT_SA_EN      = 3;
  localparam int BIT_BC_SEEN    = 4;
  localparam int BIT_PAT_SEEN   = 5;
  localparam int BIT_FILT_SEEN  = 6;
  localparam int BIT_SA_SEEN    = 7;
  localparam int BIT_STORE_WAKE = 8;

  // Resume configuration fields
  localparam int CFG_W           = 2;
  localparam int BIT_RES_CLR_STS = 0;
  localparam int BIT_RES_CLR_EN  = 1;

  // Interrupt layout: bits 3:0 follow the seen flags, bit 4 is a wake request
  localparam int IRQ_W        = 5;
  localparam int IRQ_WAKE_BIT = 4;

  // Reset values
  localparam logic [CSL_W-1:0]   CSL_RST      = 9'h000;
  localparam logic [FIELD_W-1:0] FIELD_RST    = 4'h0;
  localparam logic [CFG_W-1:0]   CFG_RST      = 2'h0;
  localparam logic [IRQ_W-1:0]   IRQ_RST      = 5'h00;

  typedef enum logic [1:0] {
    GATE_ACTIVE,
    GATE_SUSPENDED,
    GATE_WOKE_FRAME,
    GATE_WOKE_OTHER
  } wdcs_gate_e;

endpackage : wdcs_pkg

/* File: hdl/wdcs_wb_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module wdcs_wb_slave (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Register file side
  input  wire logic [31:0] rdData,
  output logic             wrStb,
  output logic             rdStb
);

  logic        ack_q;
  logic [31:0] dat_q;

  // Answer one cycle after the request, drop ack the cycle after
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dat_q <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i) begin
      dat_q <= rdData;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign wrStb    = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;
  assign rdStb    = ack_q && wb_cyc_i && wb_stb_i && !wb_we_i;

endmodule : wdcs_wb_slave
`default_nettype wire

/* File: hdl/wdcs_frame_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module wdcs_frame_gate (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Power state and wake causes
  input  wire logic suspendRetain,
  input  wire logic wakeByFrame,
  input  wire logic otherWake,
  input  wire logic storeWake,
  // Receive path
  input  wire logic frameEnd,
  input  wire logic frameGood,
  // Buffer decision
  output logic      frameStore,
  output logic      frameDrop
);

  wdcs_pkg::wdcs_gate_e state_q;
  wdcs_pkg::wdcs_gate_e state_d;
  logic                 keep;
  logic                 store_q;
  logic                 drop_q;

  always_comb begin
    state_d = state_q;
    keep    = frameGood; // [R4]
    unique case (state_q)
      wdcs_pkg::GATE_ACTIVE: begin
        if (suspendRetain) begin
          state_d = wdcs_pkg::GATE_SUSPENDED;
        end
      end
      wdcs_pkg::GATE_SUSPENDED: begin
        keep = 1'b0;
        if (!suspendRetain) begin
          state_d = wdcs_pkg::GATE_ACTIVE;
        end else if (frameEnd && wakeByFrame) begin
          keep    = storeWake && frameGood; // [R1] [R2]
          state_d = wdcs_pkg::GATE_WOKE_FRAME;
        end else if (otherWake) begin
          state_d = wdcs_pkg::GATE_WOKE_OTHER; // [R3]
        end
      end
      wdcs_pkg::GATE_WOKE_FRAME: begin
        if (!suspendRetain) begin
          state_d = wdcs_pkg::GATE_ACTIVE;
        end
      end
      wdcs_pkg::GATE_WOKE_OTHER: begin
        keep = 1'b1; // [R3]
        if (!suspendRetain) begin
          state_d = wdcs_pkg::GATE_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= wdcs_pkg::GATE_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      store_q <= 1'b0;
      drop_q  <= 1'b0;
    end else begin
      store_q <= frameEnd && keep;
      drop_q  <= frameEnd && !keep;
    end
  end

  assign frameStore = store_q;
  assign frameDrop  = drop_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_wake_frame;
    state_q == wdcs_pkg::GATE_SUSPENDED && suspendRetain && frameEnd && wakeByFrame;
  endsequence

  sequence s_other_then_frame;
    (state_q == wdcs_pkg::GATE_SUSPENDED && suspendRetain && otherWake && !frameEnd)
      ##1 (suspendRetain && !frameEnd)
      ##1 (frameEnd && suspendRetain);
  endsequence

  property p_store_wake;
    s_wake_frame and (storeWake && frameGood) |=> (frameStore && !frameDrop)
      ##1 (!frameStore || $past(frameEnd));
  endproperty
  a_store_wake: assert property (p_store_wake) else $error("waking frame not stored"); // [R1]

  property p_drop_wake;
    s_wake_frame and !storeWake |=> frameDrop && !frameStore;
  endproperty
  a_drop_wake: assert property (p_drop_wake) else $error("waking frame not dropped"); // [R2]

  property p_after_wake;
    (state_q == wdcs_pkg::GATE_WOKE_FRAME && suspendRetain && frameEnd && frameGood)
      |=> frameStore;
  endproperty
  a_after_wake: assert property (p_after_wake) else $error("later good frame lost"); // [R1]

  property p_other_wake;
    s_other_then_frame |=> frameStore;
  endproperty
  a_other_wake: assert property (p_other_wake) else $error("frame after other wake lost"); // [R3]

  property p_no_effect;
    (state_q == wdcs_pkg::GATE_ACTIVE && frameEnd) |=> (frameStore == $past(frameGood));
  endproperty
  a_no_effect: assert property (p_no_effect) else $error("store setting leaked out"); // [R4]

endmodule : wdcs_frame_gate
`default_nettype wire

/* File: hdl/wdcs_top.sv */
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// (R1) With store-waking-frame set, the waking frame and every later good filtered frame are kept.
// (R2) With store-waking-frame clear, the waking frame is dropped and only later good frames kept.
// (R3) After a wake not caused by a frame, every later received frame is kept.
// (R4) The store-waking-frame setting acts only in the frame-retaining suspend state.
// (R5) A valid frame matching the station address sets the station-address seen flag, bit 7.
// (R6) A valid wakeup filter frame sets the filter-frame seen flag, bit 6.
// (R7) A valid wake pattern packet sets the wake-pattern seen flag, bit 5.
// (R8) A valid broadcast frame sets the broadcast seen flag, bit 4.
// (R9) A completed resume clears seen flags 7 to 4 when resume-clears-status is set; reset is zero.
// (R10) A completed resume clears enables 3 to 0 when resume-clears-enables is set; reset is zero.
// (R11) Station-address enable, bit 3, lets a station-address frame wake the device.
// (R12) Filter-frame enable, bit 2, turns on wakeup filter detection and lets it wake the device.
// (R13) Wake-pattern enable, bit 1, puts the device in wake-pattern wakeup mode.
// (R14) Broadcast enable, bit 0, lets a broadcast frame wake the device.
// (R15) Software keeps every wake enable clear during normal operation.
// (R16) Seen flags clear when software writes one and hold when it writes zero.
module wdcs_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Receive path classification, valid with rxFrameEnd
  input  wire logic        rxFrameEnd,
  input  wire logic        rxFrameGood,
  input  wire logic        rxBroadcast,
  input  wire logic        rxWakePattern,
  input  wire logic        rxFilterMatch,
  input  wire logic        rxStationAddrMatch,
  // Power management
  input  wire logic        frameRetainingSuspend,
  input  wire logic        otherWakeEvent,
  input  wire logic        resumeDone,
  // Wake and buffer control
  output logic             wakeRequest,
  output logic             filterFrameWakeEnable,
  output logic             wakePatternPacketEnable,
  output logic             frameStore,
  output logic             frameDrop,
  // Interrupt
  output logic             irq
);

  localparam int FW = wdcs_pkg::FIELD_W;

  logic              wrStb;
  logic              rdStb;
  logic [31:0]       rdData;
  logic [FW-1:0]     enable_q;
  logic [FW-1:0]     seen_q;
  logic              storeWake_q;
  logic [wdcs_pkg::CFG_W-1:0] cfg_q;
  logic [wdcs_pkg::IRQ_W-1:0] irqStatus_q;
  logic [wdcs_pkg::IRQ_W-1:0] irqMask_q;
  logic              wakeRequest_q;
  logic [FW-1:0]     matchVec;
  logic [FW-1:0]     seenSet;
  logic              wakeHit;
  logic              wrCsl;
  logic              wrCfg;
  logic              wrMask;
  logic              rdIrq;
  logic [wdcs_pkg::CSL_W-1:0] cslView;

  wdcs_wb_slave wdcs_wb_slave_inst (
    .clock    (clock),
    .reset    (reset),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rdData   (rdData),
    .wrStb    (wrStb),
    .rdStb    (rdStb)
  );

  // Address decode; unmapped offsets read zero and ignore writes
  assign wrCsl  = wrStb && (wb_adr_i == wdcs_pkg::OFF_WAKE_CSL);
  assign wrCfg  = wrStb && (wb_adr_i == wdcs_pkg::OFF_RESUME_CFG) && wb_sel_i[0];
  assign wrMask = wrStb && (wb_adr_i == wdcs_pkg::OFF_IRQ_MASK) && wb_sel_i[0];
  assign rdIrq  = rdStb && (wb_adr_i == wdcs_pkg::OFF_IRQ_STATUS);

  assign cslView = {storeWake_q, seen_q, enable_q};

  always_comb begin
    rdData = 32'h00000000;
    unique case (wb_adr_i)
      wdcs_pkg::OFF_WAKE_CSL:   rdData[wdcs_pkg::CSL_W-1:0] = cslView;
      wdcs_pkg::OFF_RESUME_CFG: rdData[wdcs_pkg::CFG_W-1:0] = cfg_q;
      wdcs_pkg::OFF_IRQ_STATUS: rdData[wdcs_pkg::IRQ_W-1:0] = irqStatus_q;
      wdcs_pkg::OFF_IRQ_MASK:   rdData[wdcs_pkg::IRQ_W-1:0] = irqMask_q;
      default:                  rdData = 32'h00000000;
    endcase
  end

  // Match order follows the enable and seen bit order
  assign matchVec = {rxStationAddrMatch, rxFilterMatch, rxWakePattern, rxBroadcast};
  assign seenSet  = (rxFrameEnd && rxFrameGood) ? matchVec : wdcs_pkg::FIELD_RST; // [R5] [R6] [R7] [R8]
  assign wakeHit  = rxFrameEnd && rxFrameGood && |(enable_q & matchVec); // [R11] [R12] [R13] [R14]

  // Wake enables; a software write in the resume cycle wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      enable_q <= wdcs_pkg::FIELD_RST; // [R10]
    end else if (wrCsl && wb_sel_i[0]) begin
      enable_q <= wb_dat_i[wdcs_pkg::EN_LSB +: FW];
    end else if (resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_EN]) begin
      enable_q <= wdcs_pkg::FIELD_RST; // [R10]
    end
  end

  // Seen flags: set wins over write-one clear and resume clear
  genvar gi;
  generate
    for (gi = 0; gi < FW; gi++) begin : g_seen
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          seen_q[gi] <= 1'b0; // [R9]
        end else if (seenSet[gi]) begin
          seen_q[gi] <= 1'b1; // [R5] [R6] [R7] [R8]
        end else if (wrCsl && wb_sel_i[0] && wb_dat_i[wdcs_pkg::SEEN_LSB + gi]) begin
          seen_q[gi] <= 1'b0; // [R16]
        end else if (resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_STS]) begin
          seen_q[gi] <= 1'b0; // [R9]
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      storeWake_q <= 1'b0;
    end else if (wrCsl && wb_sel_i[1]) begin
      storeWake_q <= wb_dat_i[wdcs_pkg::BIT_STORE_WAKE];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_q <= wdcs_pkg::CFG_RST;
    end else if (wrCfg) begin
      cfg_q <= wb_dat_i[wdcs_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irqMask_q <= wdcs_pkg::IRQ_RST;
    end else if (wrMask) begin
      irqMask_q <= wb_dat_i[wdcs_pkg::IRQ_W-1:0];
    end
  end

  // Sticky interrupt status; a read clears only the bits it returned, so an
  // event landing between data capture and ack is not lost
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irqStatus_q <= wdcs_pkg::IRQ_RST;
    end else begin
      irqStatus_q <= (rdIrq ? (irqStatus_q & ~wb_dat_o[wdcs_pkg::IRQ_W-1:0]) : irqStatus_q)
                     | {wakeHit, seenSet};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wakeRequest_q <= 1'b0;
    end else begin
      wakeRequest_q <= wakeHit; // [R11] [R12] [R13] [R14]
    end
  end

  assign irq                     = |(irqStatus_q & irqMask_q);
  assign wakeRequest             = wakeRequest_q;
  assign filterFrameWakeEnable   = enable_q[wdcs_pkg::BIT_FILT_EN]; // [R12]
  assign wakePatternPacketEnable = enable_q[wdcs_pkg::BIT_PAT_EN]; // [R13]

  // Store decision in the frame-retaining suspend
  wdcs_frame_gate wdcs_frame_gate_inst (
    .clock         (clock),
    .reset         (reset),
    .suspendRetain (frameRetainingSuspend),
    .wakeByFrame   (wakeHit),
    .otherWake     (otherWakeEvent),
    .storeWake     (storeWake_q),
    .frameEnd      (rxFrameEnd),
    .frameGood     (rxFrameGood),
    .frameStore    (frameStore),
    .frameDrop     (frameDrop)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_good_frame;
    rxFrameEnd && rxFrameGood;
  endsequence

  property p_sa_seen;
    s_good_frame and rxStationAddrMatch |=> seen_q[3];
  endproperty
  a_sa_seen: assert property (p_sa_seen) else $error("station match flag missed"); // [R5]

  property p_filt_seen;
    s_good_frame and rxFilterMatch |=> seen_q[2];
  endproperty
  a_filt_seen: assert property (p_filt_seen) else $error("filter frame flag missed"); // [R6]

  property p_pat_seen;
    s_good_frame and rxWakePattern |=> seen_q[1];
  endproperty
  a_pat_seen: assert property (p_pat_seen) else $error("wake pattern flag missed"); // [R7]

  property p_bc_seen;
    s_good_frame and rxBroadcast |=> seen_q[0];
  endproperty
  a_bc_seen: assert property (p_bc_seen) else $error("broadcast flag missed"); // [R8]

  property p_resume_sts;
    (resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_STS] && !rxFrameEnd) |=> seen_q == 4'h0;
  endproperty
  a_resume_sts: assert property (p_resume_sts) else $error("resume left seen flags"); // [R9]

  property p_resume_en;
    (resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_EN] && !wrCsl) |=> enable_q == 4'h0;
  endproperty
  a_resume_en: assert property (p_resume_en) else $error("resume left enables"); // [R10]

  property p_wake;
    s_good_frame and (|(enable_q & matchVec))
      |=> wakeRequest ##1 (!wakeRequest || $past(rxFrameEnd));
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong"); // [R11]

  property p_no_wake;
    !(rxFrameEnd && rxFrameGood && |(enable_q & matchVec)) |=> !wakeRequest;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("spurious wake request"); // [R14]

  property p_w1c;
    (wrCsl && wb_sel_i[0] && wb_dat_i[7] && !seenSet[3]) |=> !seen_q[3];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [R16]

  property p_w0_hold;
    (wrCsl && !wb_dat_i[wdcs_pkg::BIT_BC_SEEN] && seen_q[0]
      && !(resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_STS])) |=> seen_q[0];
  endproperty
  a_w0_hold: assert property (p_w0_hold) else $error("write zero cleared flag"); // [R16]

  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus request not answered");

  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held too long");

  property p_irq_set;
    (rxFrameEnd && rxFrameGood && rxBroadcast && irqMask_q[0] && !wrMask) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("unmasked event gave no interrupt"); // [R8]

  property p_irq_clear;
    (rdIrq && !(rxFrameEnd && rxFrameGood))
      |=> (irqStatus_q & $past(wb_dat_o[wdcs_pkg::IRQ_W-1:0])) == wdcs_pkg::IRQ_RST;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("read left status bits set");

  property p_en_write;
    (wrCsl && wb_sel_i[0]) |=> enable_q == $past(wb_dat_i[wdcs_pkg::EN_LSB +: FW]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_lane_hold;
    (wrCsl && !wb_sel_i[0] && !(resumeDone && cfg_q[wdcs_pkg::BIT_RES_CLR_EN]))
      |=> $stable(enable_q);
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("masked lane changed enables");

  property p_bad_frame;
    (rxFrameEnd && !rxFrameGood && !wrCsl && !resumeDone) |=> $stable(seen_q);
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame set a flag"); // [R5]

  property p_one_verdict;
    rxFrameEnd |=> frameStore != frameDrop;
  endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("frame kept and dropped"); // [R2]

  property p_resume_keep;
    (resumeDone && !cfg_q[wdcs_pkg::BIT_RES_CLR_EN] && !wrCsl) |=> $stable(enable_q);
  endproperty
  a_resume_keep: assert property (p_resume_keep) else $error("resume cleared enables"); // [R10]

endmodule : wdcs_top
`default_nettype wire

/* File: bench/wdcs_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module wdcs_top_tb;
  logic        clock;
  logic        reset;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rxFrameEnd;
  logic        rxFrameGood;
  logic        rxBroadcast;
  logic        rxWakePattern;
  logic        rxFilterMatch;
  logic        rxStationAddrMatch;
  logic        frameRetainingSuspend;
  logic        otherWakeEvent;
  logic        resumeDone;
  logic        wakeRequest;
  logic        filterFrameWakeEnable;
  logic        wakePatternPacketEnable;
  logic        frameStore;
  logic        frameDrop;
  logic        irq;
  int          numErrors;
  int          cmpCount;
  logic [31:0] rd;
  logic [2:0]  res;

  wdcs_top wdcs_top_inst (
    .clock                   (clock),
    .reset                   (reset),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .rxFrameEnd              (rxFrameEnd),
    .rxFrameGood             (rxFrameGood),
    .rxBroadcast             (rxBroadcast),
    .rxWakePattern           (rxWakePattern),
    .rxFilterMatch           (rxFilterMatch),
    .rxStationAddrMatch      (rxStationAddrMatch),
    .frameRetainingSuspend   (frameRetainingSuspend),
    .otherWakeEvent          (otherWakeEvent),
    .resumeDone              (resumeDone),
    .wakeRequest             (wakeRequest),
    .filterFrameWakeEnable   (filterFrameWakeEnable),
    .wakePatternPacketEnable (wakePatternPacketEnable),
    .frameStore              (frameStore),
    .frameDrop               (frameDrop),
    .irq                     (irq)
  );

  always #2.5 clock = ~clock;

  task automatic results;
    $display("checks %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] dat, output logic [31:0] data);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      numErrors++;
      $display("unexpected ack at %h expected 1 seen 0", adr);
      results();
    end else begin
      data = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask : wbXfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wbXfer(1'b1, adr, 4'hF, dat, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wbXfer(1'b0, adr, 4'hF, 32'h0000_0000, d);
    check("read data", d, exp);
  endtask : rdChk

  // Class order {station, filter, pattern, broadcast}; result {wake, store, drop}
  task automatic frame(input logic good, input logic [3:0] cls, output logic [2:0] r);
    @(posedge clock);
    rxFrameEnd <= 1'b1;
    rxFrameGood <= good;
    {rxStationAddrMatch, rxFilterMatch, rxWakePattern, rxBroadcast} <= cls;
    @(posedge clock);
    rxFrameEnd <= 1'b0;
    #1 r = {wakeRequest, frameStore, frameDrop};
  endtask : frame

  task automatic pulse(input int which);
    @(posedge clock);
    if (which == 0) resumeDone <= 1'b1;
    else otherWakeEvent <= 1'b1;
    @(posedge clock);
    resumeDone <= 1'b0;
    otherWakeEvent <= 1'b0;
  endtask : pulse

  task automatic suspend(input logic on);
    @(posedge clock);
    frameRetainingSuspend <= on;
    @(posedge clock);
  endtask : suspend

  initial begin
    repeat (5000) @(posedge clock);
    numErrors++;
    results();
  end

  initial begin
    clock = 1'b0; reset = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0000_0000;
    rxFrameEnd = 1'b0; rxFrameGood = 1'b0; rxBroadcast = 1'b0; rxWakePattern = 1'b0;
    rxFilterMatch = 1'b0; rxStationAddrMatch = 1'b0; frameRetainingSuspend = 1'b0;
    otherWakeEvent = 1'b0; resumeDone = 1'b0; numErrors = 0; cmpCount = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdChk(8'h00, 32'h0000_0000);
    rdChk(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_010F);
    #1 check("enable outputs", {30'h0, filterFrameWakeEnable, wakePatternPacketEnable}, 32'h3);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h10, 32'hFFFF_FFFF);
    rdChk(8'h00, 32'h0000_010F);
    // Broadcast wakes, raises the unmasked interrupt, read clears status
    frame(1'b1, 4'h1, res);
    check("bcast result", {29'h0, res}, 32'h6);
    check("irq", {31'h0, irq}, 32'h1);
    rdChk(8'h08, 32'h0000_0011);
    @(posedge clock);
    #1 check("irq", {31'h0, irq}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      frame(1'b1, 4'h1 << i, res);
      check("class result", {29'h0, res}, 32'h6);
    end
    rdChk(8'h00, 32'h0000_01FF);
    wr(8'h00, 32'h0000_01FF);
    rdChk(8'h00, 32'h0000_010F);
    frame(1'b0, 4'hF, res);
    check("bad frame", {29'h0, res}, 32'h1);
    rdChk(8'h00, 32'h0000_010F);
    wr(8'h00, 32'h0000_010E);
    frame(1'b1, 4'h1, res);
    check("disabled bcast", {29'h0, res}, 32'h2);
    rdChk(8'h00, 32'h0000_011E);
    wr(8'h00, 32'h0000_010E);
    rdChk(8'h00, 32'h0000_011E);
    wbXfer(1'b1, 8'h00, 4'h2, 32'h0000_0000, rd);
    rdChk(8'h00, 32'h0000_001E);
    // Resume clears seen only, then enables only
    wr(8'h04, 32'h0000_0001);
    pulse(0);
    rdChk(8'h00, 32'h0000_000E);
    frame(1'b1, 4'h2, res);
    wr(8'h04, 32'h0000_0002);
    rdChk(8'h04, 32'h0000_0002);
    pulse(0);
    rdChk(8'h00, 32'h0000_0020);
    wr(8'h00, 32'h0000_0020);
    // Buffer decisions in the frame-retaining suspend state, then one in the active state
    wr(8'h00, 32'h0000_010F);
    suspend(1'b1);
    frame(1'b1, 4'h0, res);
    check("non-waking", {30'h0, res[1:0]}, 32'h1);
    frame(1'b1, 4'h1, res);
    check("waking kept", {30'h0, res[1:0]}, 32'h2);
    frame(1'b1, 4'h0, res);
    check("later good", {30'h0, res[1:0]}, 32'h2);
    frame(1'b0, 4'h0, res);
    check("later bad", {30'h0, res[1:0]}, 32'h1);
    suspend(1'b0);
    wr(8'h00, 32'h0000_000F);
    suspend(1'b1);
    frame(1'b1, 4'h1, res);
    check("waking dropped", {30'h0, res[1:0]}, 32'h1);
    frame(1'b1, 4'h0, res);
    check("later good", {30'h0, res[1:0]}, 32'h2);
    suspend(1'b0);
    suspend(1'b1);
    pulse(1);
    frame(1'b0, 4'h0, res);
    check("other wake", {30'h0, res[1:0]}, 32'h2);
    suspend(1'b0);
    wr(8'h00, 32'h0000_0100);
    frame(1'b1, 4'h1, res);
    check("active store", {30'h0, res[1:0]}, 32'h2);
    results();
  end
endmodule : wdcs_top_tb
`default_nettype wire
